//--- rtl/scsidp_pkg.sv
// Purpose: Constants for the SCSI data path and sync rate block.
// Assumes: 8-bit register port, 20 MHz core clock.
// Notes: Offsets are register indices on the plain port.
package scsidp_pkg;
   // -----------------------------------------------------------------
   // Register offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] A_DMA_FIFO_COUNT = 8'h00;
   localparam logic [7:0] A_DBC = 8'h01;
   localparam logic [7:0] A_SST0 = 8'h02;
   localparam logic [7:0] A_SST1 = 8'h03;
   localparam logic [7:0] A_OWN_ID_REGISTER = 8'h04;
   localparam logic [7:0] A_IST0 = 8'h05;
   localparam logic [7:0] A_IEN0 = 8'h06;
   localparam logic [7:0] A_TRANSFER_CONTROL = 8'h07;
   localparam logic [7:0] A_SC3 = 8'h08;
   localparam logic [7:0] A_DATA = 8'h09;
   localparam logic [7:0] RST_VAL = 8'h00;
   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int SST0_OUTPUT_LATCH = 5;
   localparam int SST0_OUTPUT_REGISTER = 6;
   localparam int SST0_INPUT_LATCH = 7;
   localparam int OWN_ID_REGISTER_SEL_EN = 5;
   localparam int OWN_ID_REGISTER_RSL_EN = 6;
   localparam int IST_SEL = 5;
   localparam int IST_RSL = 4;
   localparam int SX_TP_LO = 5;
   localparam int SC3_SCF_LO = 4;
   localparam int SC3_TGT = 3;
   localparam int SC3_SEND = 7;
   // -----------------------------------------------------------------
   // Sizes and timing
   // -----------------------------------------------------------------
   localparam int LANES = 4;
   localparam int LANE_DEPTH = 20;
   localparam logic [6:0] FIFO_BYTES = 7'h50;
   localparam logic [6:0] PTR_LAST = 7'h4f;
   localparam logic [3:0] SFIFO_DEPTH = 4'h8;
   localparam logic [2:0] RX_TICKS = 3'h4;
   localparam logic [3:0] TP_BASE = 4'h2;
   localparam int CLK_NS = 50;
   localparam int RX_MIN_NS = 80;
   localparam int SEND_FAST_NS = 100;
   localparam int SEND_SLOW_NS = 200;
   localparam logic [7:0] SEND_FAST_CYC =
      8'((SEND_FAST_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] SEND_SLOW_CYC =
      8'((SEND_SLOW_NS + CLK_NS - 1) / CLK_NS);

   typedef enum logic [2:0] {
      TX_IDLE = 3'b000,
      TX_SETUP = 3'b001,
      TX_WAIT = 3'b010,
      TX_HOLD = 3'b011,
      TX_PER = 3'b100
   } scsidp_tx_e;

   // Divisor applied to the core clock for the sync logic.
   function automatic logic [3:0] scsidp_scf_div(input logic [2:0] f);
      case (f)
         3'h0: scsidp_scf_div = 4'h1;
         3'h1: scsidp_scf_div = 4'h1;
         3'h2: scsidp_scf_div = 4'h2;
         3'h3: scsidp_scf_div = 4'h3;
         3'h4: scsidp_scf_div = 4'h4;
         3'h5: scsidp_scf_div = 4'h6;
         default: scsidp_scf_div = 4'h8;
      endcase
   endfunction : scsidp_scf_div
endpackage : scsidp_pkg

//--- rtl/scsidp_top.sv
// Purpose: SCSI data path, residual status and sync rate dividers.
// Assumes: Single-ended bus, all bus signals low when asserted.
// Notes: Registers are 8 bits wide on a plain strobe port.
`timescale 1ns/1ps
module scsidp_top
   import scsidp_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic [7:0] scsi_data_n_i,
   output logic [7:0] scsi_data_n_o,
   output logic scsi_data_oe,
   input wire logic scsi_req_n_i,
   output logic scsi_req_n_o,
   output logic scsi_req_oe,
   input wire logic scsi_ack_n_i,
   output logic scsi_ack_n_o,
   output logic scsi_ack_oe,
   input wire logic scsi_sel_n_i,
   input wire logic scsi_bsy_n_i,
   input wire logic scsi_io_n_i,
   input wire logic sel_instr_busy,
   output logic branch_alt,
   output logic interrupt_request_n
);
   // -----------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------
   logic [6:0] dma_fifo_count_r, dbc_r, fill_r, wp_r, rp_r;
   logic [7:0] own_id_register_r, ist_r, ien_r, transfer_control_r, sc3_r;
   logic [7:0] output_latch_r, output_register_r, input_latch_r;
   logic output_latch_full_r, output_register_full_r, input_latch_full_r;
   logic [7:0] lane_mem [LANES][LANE_DEPTH];
   logic [7:0] sf_mem [8];
   logic [2:0] sf_wp_r, sf_rp_r;
   logic [3:0] sf_cnt_r;
   logic wr_data, rd_data, wr_dbc, rd_ist;
   logic tgt, send, sync_md;
   assign wr_data = reg_wr && reg_addr == A_DATA;
   assign rd_data = reg_rd && reg_addr == A_DATA;
   assign wr_dbc = reg_wr && reg_addr == A_DBC;
   assign rd_ist = reg_rd && reg_addr == A_IST0;
   assign tgt = sc3_r[SC3_TGT];
   assign send = sc3_r[SC3_SEND];
   assign sync_md = transfer_control_r[3:0] != 4'h0;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         own_id_register_r <= RST_VAL;
         ien_r <= RST_VAL;
         transfer_control_r <= RST_VAL;
         sc3_r <= RST_VAL;
      end else if (reg_wr) begin
         case (reg_addr)
            A_OWN_ID_REGISTER: own_id_register_r <= reg_wdata;
            A_IEN0: ien_r <= reg_wdata;
            A_TRANSFER_CONTROL: transfer_control_r <= reg_wdata;
            A_SC3: sc3_r <= reg_wdata;
            default: ;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Bus input synchronisers, asserted-low pins inverted
   // -----------------------------------------------------------------
   logic [12:0] raw, s1_r, s2_r, s3_r, lvl_r;
   assign raw = ~{scsi_io_n_i, scsi_bsy_n_i, scsi_sel_n_i,
                  scsi_ack_n_i, scsi_req_n_i, scsi_data_n_i};
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         lvl_r <= '0;
      end else begin
         s1_r <= raw;
         s2_r <= s1_r;
         s3_r <= s2_r;
         lvl_r <= (s2_r & s3_r) | (lvl_r & (s2_r ^ s3_r));
      end
   end
   logic in_strb, strb_d_r, strb_rise, strb_fall;
   assign in_strb = tgt ? lvl_r[9] : lvl_r[8];
   assign strb_rise = in_strb && !strb_d_r;
   assign strb_fall = !in_strb && strb_d_r;
   always_ff @(posedge core_clk) begin
      if (!rst_n) strb_d_r <= 1'b0;
      else strb_d_r <= in_strb;
   end

   // -----------------------------------------------------------------
   // Sync clock divider and receive rate gate
   // -----------------------------------------------------------------
   logic [3:0] scf_div, scf_cnt_r;
   logic scf_tick, rx_ok;
   logic [2:0] rx_gap_r;
   assign scf_div = scsidp_scf_div(sc3_r[SC3_SCF_LO +: 3]);
   assign scf_tick = scf_cnt_r == scf_div - 4'h1;
   assign rx_ok = rx_gap_r >= RX_TICKS;
   always_ff @(posedge core_clk) begin
      if (!rst_n || scf_tick) scf_cnt_r <= 4'h0;
      else scf_cnt_r <= scf_cnt_r + 4'h1;
   end
   logic sf_push, sf_pop;
   assign sf_push = !send && sync_md && strb_rise && rx_ok &&
                    sf_cnt_r != SFIFO_DEPTH;
   always_ff @(posedge core_clk) begin
      if (!rst_n || sf_push) rx_gap_r <= 3'h0;
      else if (scf_tick && !rx_ok) rx_gap_r <= rx_gap_r + 3'h1;
   end

   // -----------------------------------------------------------------
   // DMA FIFO
   // -----------------------------------------------------------------
   logic push, pop, ld_output_latch, rx_push;
   logic [7:0] push_d, fifo_q;
   assign rx_push = sync_md ? sf_cnt_r != 4'h0 : input_latch_full_r;
   assign push = (send ? wr_data : rx_push) && fill_r != FIFO_BYTES;
   assign ld_output_latch = send && !output_latch_full_r && fill_r != 7'h0;
   assign pop = (send ? ld_output_latch : rd_data) && fill_r != 7'h0;
   assign push_d = send ? reg_wdata : (sync_md ? sf_mem[sf_rp_r] : input_latch_r);
   assign fifo_q = lane_mem[rp_r[1:0]][rp_r[6:2]];
   assign sf_pop = !send && sync_md && push;

   always_ff @(posedge core_clk) begin
      if (push) lane_mem[wp_r[1:0]][wp_r[6:2]] <= push_d;
   end
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         wp_r <= 7'h0;
         rp_r <= 7'h0;
         fill_r <= 7'h0;
      end else begin
         if (push) wp_r <= wp_r == PTR_LAST ? 7'h0 : wp_r + 7'h1;
         if (pop) rp_r <= rp_r == PTR_LAST ? 7'h0 : rp_r + 7'h1;
         fill_r <= fill_r + 7'(push) - 7'(pop);
      end
   end
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         dma_fifo_count_r <= 7'h0;
         dbc_r <= 7'h0;
      end else begin
         if (push) dma_fifo_count_r <= dma_fifo_count_r + 7'h1;
         if (wr_dbc) dbc_r <= reg_wdata[6:0];
         else if (pop) dbc_r <= dbc_r + 7'h1;
      end
   end

   // -----------------------------------------------------------------
   // Sync receive SCSI FIFO
   // -----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (sf_push) sf_mem[sf_wp_r] <= lvl_r[7:0];
   end
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         sf_wp_r <= 3'h0;
         sf_rp_r <= 3'h0;
         sf_cnt_r <= 4'h0;
      end else begin
         if (sf_push) sf_wp_r <= sf_wp_r + 3'h1;
         if (sf_pop) sf_rp_r <= sf_rp_r + 3'h1;
         sf_cnt_r <= sf_cnt_r + 4'(sf_push) - 4'(sf_pop);
      end
   end

   // -----------------------------------------------------------------
   // Send path and handshake
   // -----------------------------------------------------------------
   scsidp_tx_e tx_r;
   logic [7:0] tmr_r, per_cyc, per_raw;
   logic strb_out_r, tx_done, input_latch_cap;
   assign per_raw = {4'h0, scf_div} *
                    ({5'h0, transfer_control_r[SX_TP_LO +: 3]} + {4'h0, TP_BASE});
   assign per_cyc = per_raw < SEND_FAST_CYC ? SEND_FAST_CYC : per_raw;
   assign tx_done = (tx_r == TX_WAIT && in_strb) ||
                    (tx_r == TX_PER && tmr_r == 8'h0);
   assign input_latch_cap = !send && !sync_md && strb_rise && !input_latch_full_r;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         tx_r <= TX_IDLE;
         tmr_r <= 8'h0;
      end else begin
         case (tx_r)
            TX_IDLE: begin
               tmr_r <= {5'h0, sc3_r[2:0]};
               if (send && (sync_md ? output_register_full_r : output_latch_full_r))
                  tx_r <= TX_SETUP;
            end
            TX_SETUP: begin
               tmr_r <= tmr_r - 8'h1;
               if (tmr_r == 8'h0) begin
                  tx_r <= sync_md ? TX_PER : TX_WAIT;
                  tmr_r <= per_cyc - 8'h1;
               end
            end
            TX_WAIT: if (in_strb) tx_r <= TX_HOLD;
            TX_HOLD: if (!in_strb) tx_r <= TX_IDLE;
            TX_PER: begin
               tmr_r <= tmr_r - 8'h1;
               if (tmr_r == 8'h0 && output_latch_full_r) begin
                  tmr_r <= per_cyc - 8'h1;
               end else if (tmr_r == 8'h0) begin
                  tx_r <= TX_IDLE;
               end
            end
            default: tx_r <= TX_IDLE;
         endcase
      end
   end
   always_ff @(posedge core_clk) begin
      if (!rst_n) strb_out_r <= 1'b0;
      else if (tx_r == TX_SETUP && tmr_r == 8'h0) strb_out_r <= 1'b1;
      else if (tx_r == TX_WAIT && in_strb) strb_out_r <= 1'b0;
      else if (tx_r == TX_PER && tmr_r == 8'h0 && output_latch_full_r)
         strb_out_r <= 1'b1;
      else if (tx_r == TX_PER && tmr_r == {1'b0, per_cyc[7:1]})
         strb_out_r <= 1'b0;
      else if (input_latch_cap) strb_out_r <= 1'b1;
      else if (!send && strb_fall) strb_out_r <= 1'b0;
   end

   // -----------------------------------------------------------------
   // Latches between FIFO and bus
   // -----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         output_latch_full_r <= 1'b0;
         output_register_full_r <= 1'b0;
         input_latch_full_r <= 1'b0;
         output_latch_r <= 8'h0;
         output_register_r <= 8'h0;
         input_latch_r <= 8'h0;
      end else begin
         if (ld_output_latch) begin
            output_latch_r <= fifo_q;
            output_latch_full_r <= 1'b1;
         end else if (sync_md && output_latch_full_r &&
                      (!output_register_full_r || tx_done)) begin
            output_register_r <= output_latch_r;
            output_latch_full_r <= 1'b0;
            output_register_full_r <= 1'b1;
         end else if (!sync_md && tx_done) begin
            output_latch_full_r <= 1'b0;
         end
         if (sync_md && tx_done && !output_latch_full_r) output_register_full_r <= 1'b0;
         if (input_latch_cap) begin
            input_latch_r <= lvl_r[7:0];
            input_latch_full_r <= 1'b1;
         end else if (!sync_md && push && !send) begin
            input_latch_full_r <= 1'b0;
         end
      end
   end

   // -----------------------------------------------------------------
   // Selection, reselection and events
   // -----------------------------------------------------------------
   logic sel_act, seen_r, sel_evt, rsl_evt;
   assign sel_act = lvl_r[10] && !lvl_r[11] && lvl_r[own_id_register_r[2:0]];
   assign sel_evt = sel_act && !seen_r && !lvl_r[12] &&
                    own_id_register_r[OWN_ID_REGISTER_SEL_EN];
   assign rsl_evt = sel_act && !seen_r && lvl_r[12] &&
                    own_id_register_r[OWN_ID_REGISTER_RSL_EN];
   always_ff @(posedge core_clk) begin
      if (!rst_n) seen_r <= 1'b0;
      else seen_r <= sel_act;
   end
   always_ff @(posedge core_clk) begin
      if (!rst_n) ist_r <= RST_VAL;
      else begin
         ist_r <= (rd_ist ? 8'h00 : ist_r) |
                  {2'h0, sel_evt, rsl_evt, 4'h0};
      end
   end
   always_ff @(posedge core_clk) begin
      if (!rst_n) branch_alt <= 1'b0;
      else branch_alt <= (sel_evt || rsl_evt) && sel_instr_busy;
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         interrupt_request_n <= 1'b1;
         scsi_data_n_o <= 8'hff;
         scsi_data_oe <= 1'b0;
         scsi_req_n_o <= 1'b1;
         scsi_req_oe <= 1'b0;
         scsi_ack_n_o <= 1'b1;
         scsi_ack_oe <= 1'b0;
      end else begin
         interrupt_request_n <= (ist_r & ien_r) == 8'h00;
         scsi_data_n_o <= ~(sync_md ? output_register_r : output_latch_r);
         scsi_data_oe <= send && tx_r != TX_IDLE;
         scsi_req_n_o <= 1'b0;
         scsi_req_oe <= tgt && strb_out_r;
         scsi_ack_n_o <= 1'b0;
         scsi_ack_oe <= !tgt && strb_out_r;
      end
   end
   always_ff @(posedge core_clk) begin
      if (!rst_n) reg_rdata <= 8'h00;
      else if (!reg_rd) reg_rdata <= 8'h00;
      else begin
         case (reg_addr)
            A_DMA_FIFO_COUNT: reg_rdata <= {1'b0, dma_fifo_count_r};
            A_DBC: reg_rdata <= {1'b0, dbc_r};
            A_SST0: reg_rdata <= {input_latch_full_r, output_register_full_r,
                                  output_latch_full_r, 5'h0};
            A_SST1: reg_rdata <= {sf_cnt_r, 4'h0};
            A_OWN_ID_REGISTER: reg_rdata <= own_id_register_r;
            A_IST0: reg_rdata <= ist_r;
            A_IEN0: reg_rdata <= ien_r;
            A_TRANSFER_CONTROL: reg_rdata <= transfer_control_r;
            A_SC3: reg_rdata <= sc3_r;
            A_DATA: reg_rdata <= (send || fill_r == 7'h0) ? 8'h00 : fifo_q;
            default: reg_rdata <= 8'h00;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   property p_cap;
      fill_r <= FIFO_BYTES && wp_r <= PTR_LAST;
   endproperty
   a_cap: assert property (p_cap) else $error("fifo overrun");
   property p_dbc;
      pop && !wr_dbc |=> dbc_r == $past(dbc_r) + 7'h1;
   endproperty
   a_dbc: assert property (p_dbc) else $error("dbc step");
   property p_output_latch;
      reg_rd && reg_addr == A_SST0 |=>
         reg_rdata[SST0_OUTPUT_LATCH] == $past(output_latch_full_r);
   endproperty
   a_output_latch: assert property (p_output_latch) else $error("output_latch bit");
   property p_output_register;
      reg_rd && reg_addr == A_SST0 |=>
         reg_rdata[SST0_OUTPUT_REGISTER] == $past(output_register_full_r);
   endproperty
   a_output_register: assert property (p_output_register) else $error("output_register bit");
   property p_input_latch;
      reg_rd && reg_addr == A_SST0 |=>
         reg_rdata[SST0_INPUT_LATCH] == $past(input_latch_full_r);
   endproperty
   a_input_latch: assert property (p_input_latch) else $error("input_latch bit");
   property p_sst1;
      reg_rd && reg_addr == A_SST1 |=> reg_rdata[7:4] == $past(sf_cnt_r);
   endproperty
   a_sst1: assert property (p_sst1) else $error("sst1 count");
   property p_selen;
      sel_evt |-> own_id_register_r[OWN_ID_REGISTER_SEL_EN] ##1 ist_r[IST_SEL];
   endproperty
   a_selen: assert property (p_selen) else $error("sel flag");
   property p_branch;
      (rsl_evt || sel_evt) && sel_instr_busy |=> branch_alt ##1 !branch_alt;
   endproperty
   a_branch: assert property (p_branch) else $error("branch");
   property p_irq;
      (ist_r & ien_r) != 8'h00 |=> !interrupt_request_n;
   endproperty
   a_irq: assert property (p_irq) else $error("irq level");
endmodule : scsidp_top

//--- tb/scsidp_peer.sv
// Purpose: Behavioural SCSI peer facing the data path block.
// Assumes: Bus lines are low when asserted and pulled high when free.
// Notes: Answers async strobes after a lag and logs each byte sent.
`timescale 1ns/1ps
module scsidp_peer (
   input wire logic clk,
   input wire logic [7:0] dev_data_n,
   input wire logic dev_strobe,
   input wire logic hold,
   input wire logic sync,
   input wire logic [3:0] lag,
   output logic peer_strobe_n,
   output logic [7:0] peer_data_n,
   output logic sel_n,
   output logic bsy_n,
   output logic io_n,
   output logic got,
   output logic [7:0] got_byte,
   output logic [7:0] got_gap
);
   logic ans_n = 1'b1, tx_n = 1'b1, seen = 1'b0, sel_r = 1'b1, io_r = 1'b1;
   logic [7:0] tx_d = 8'hff, sid_d = 8'hff, since = 8'h00;
   logic [3:0] wait_c = 4'h0;
   // ------------------------------------------------------------
   // Bus levels
   // ------------------------------------------------------------
   assign peer_strobe_n = ans_n & tx_n;
   assign peer_data_n = tx_d & sid_d;
   assign sel_n = sel_r;
   assign io_n = io_r;
   assign bsy_n = 1'b1;
   // ------------------------------------------------------------
   // Answer and logging
   // ------------------------------------------------------------
   always @(posedge clk) begin
      got <= dev_strobe && !seen;
      got_byte <= ~dev_data_n;
      got_gap <= since;
      seen <= dev_strobe;
      if (dev_strobe && !seen) since <= 8'h01;
      else if (since != 8'hff) since <= since + 8'h01;
      if (!dev_strobe) wait_c <= 4'h0;
      else if (!hold && !sync && wait_c != 4'hf) wait_c <= wait_c + 4'h1;
      ans_n <= !(dev_strobe && !hold && !sync && wait_c >= lag);
   end
   task automatic send_sync(input logic [7:0] b);
      @(posedge clk);
      tx_d <= ~b;
      tx_n <= 1'b0;
      repeat (2) @(posedge clk);
      tx_n <= 1'b1;
      repeat (8) @(posedge clk);
      tx_d <= 8'hff;
   endtask : send_sync
   task automatic select(input logic resel, input logic [2:0] id);
      @(posedge clk);
      sel_r <= 1'b0;
      io_r <= ~resel;
      sid_d <= ~(8'h01 << id);
      repeat (10) @(posedge clk);
      sel_r <= 1'b1;
      io_r <= 1'b1;
      sid_d <= 8'hff;
      repeat (4) @(posedge clk);
   endtask : select
endmodule : scsidp_peer

//--- tb/scsidp_top_test.sv
// Purpose: Self-checking bench for the SCSI data path block.
// Assumes: Peer model on the bus side, register port from the bench.
// Notes: Reads and sent bytes are checked against queued notes.
`timescale 1ns/1ps
module scsidp_top_test
   import scsidp_pkg::*;
;
   logic core_clk, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_p = 1'b0;
   logic sel_instr_busy = 1'b0, tgt = 1'b0, hold = 1'b0, sync = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, scsi_data_n_o;
   logic scsi_data_oe, scsi_req_n_o, scsi_req_oe, scsi_ack_n_o, scsi_ack_oe;
   logic branch_alt, interrupt_request_n, p_strobe_n, sel_n, bsy_n, io_n;
   logic got;
   logic [7:0] p_data_n, got_byte, got_gap, data_w, rx_b[3];
   logic req_w, ack_w;
   logic [15:0] note;
   logic [31:0] seed = 32'ha84b;
   logic [7:0] rq[$];
   logic [15:0] bq[$];
   int err_total = 0, n_checks = 0, cyc = 0, n_br = 0;
   logic [2:0] scf_t[4] = '{3'h7, 3'h1, 3'h1, 3'h5};
   logic [2:0] tp_t[4] = '{3'h7, 3'h0, 3'h2, 3'h1};
   // ------------------------------------------------------------
   // Wiring
   // ------------------------------------------------------------
   assign data_w = scsi_data_oe ? scsi_data_n_o : p_data_n;
   assign req_w = scsi_req_oe ? scsi_req_n_o : (tgt ? 1'b1 : p_strobe_n);
   assign ack_w = scsi_ack_oe ? scsi_ack_n_o : (tgt ? p_strobe_n : 1'b1);
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   scsidp_top i_dut (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .scsi_data_n_i(data_w),
      .scsi_data_n_o(scsi_data_n_o),
      .scsi_data_oe(scsi_data_oe),
      .scsi_req_n_i(req_w),
      .scsi_req_n_o(scsi_req_n_o),
      .scsi_req_oe(scsi_req_oe),
      .scsi_ack_n_i(ack_w),
      .scsi_ack_n_o(scsi_ack_n_o),
      .scsi_ack_oe(scsi_ack_oe),
      .scsi_sel_n_i(sel_n),
      .scsi_bsy_n_i(bsy_n),
      .scsi_io_n_i(io_n),
      .sel_instr_busy(sel_instr_busy),
      .branch_alt(branch_alt),
      .interrupt_request_n(interrupt_request_n)
   );
   scsidp_peer i_peer (
      .clk(core_clk),
      .dev_data_n(scsi_data_n_o),
      .dev_strobe(scsi_req_oe | scsi_ack_oe),
      .hold(hold),
      .sync(sync),
      .lag(4'h6),
      .peer_strobe_n(p_strobe_n),
      .peer_data_n(p_data_n),
      .sel_n(sel_n),
      .bsy_n(bsy_n),
      .io_n(io_n),
      .got(got),
      .got_byte(got_byte),
      .got_gap(got_gap)
   );
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic logic [7:0] period(input int k);
      logic [7:0] d;
      case (scf_t[k])
         3'h0, 3'h1: d = 8'h01;
         3'h5: d = 8'h06;
         3'h6, 3'h7: d = 8'h08;
         default: d = 8'(scf_t[k]);
      endcase
      d = d * (8'(tp_t[k]) + 8'h02);
      return (d < 8'h02) ? 8'h02 : d;
   endfunction : period
   task automatic tally(input logic [7:0] g, input logic [7:0] e);
      n_checks++;
      if (g !== e) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : tally
   task automatic cmp_reg(input logic [7:0] g, input logic [7:0] e);
      tally(g, e);
   endtask : cmp_reg
   task automatic cmp_bus(input logic [7:0] g, input logic [7:0] e);
      tally(g, e);
   endtask : cmp_bus
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_rd <= 1'b0;
      reg_wr <= 1'b1;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      rq.push_back(e);
   endtask : rd
   task automatic idle(input int n);
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      repeat (n) @(posedge core_clk);
   endtask : idle
   task automatic settle();
      while (bq.size() != 0) @(posedge core_clk);
      repeat (20) @(posedge core_clk);
   endtask : settle
   task automatic wrap_up();
      if (err_total == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : wrap_up
   always @(posedge core_clk) begin
      if (rd_p) cmp_reg(reg_rdata, rq.pop_front());
      rd_p <= reg_rd;
      if (branch_alt === 1'b1) n_br++;
      if (got === 1'b1) begin
         note = (bq.size() != 0) ? bq.pop_front() : 16'hxxxx;
         cmp_bus(got_byte, note[7:0]);
         if (note[15:8] != 8'h00) cmp_bus(got_gap, note[15:8]);
      end
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         wrap_up();
      end
   end
   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   initial begin
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      for (int a = 0; a < 10; a++) rd(8'(a), RST_VAL);
      wr(8'h3c, 8'h5a);
      rd(8'h3c, 8'h00);
      wr(A_TRANSFER_CONTROL, 8'he3);
      rd(A_TRANSFER_CONTROL, 8'he3);
      wr(A_DBC, 8'hff);
      rd(A_DBC, 8'h7f);
      hold <= 1'b1;
      wr(A_SC3, 8'h80);
      wr(A_TRANSFER_CONTROL, 8'h00);
      wr(A_DBC, 8'h00);
      for (int i = 0; i < 82; i++) begin
         seed = lfsr(seed);
         wr(A_DATA, seed[7:0]);
         if (i < 81) bq.push_back({8'h00, seed[7:0]});
      end
      idle(10);
      rd(A_DMA_FIFO_COUNT, 8'h51);
      rd(A_DBC, 8'h01);
      rd(A_SST0, 8'h20);
      idle(2);
      hold <= 1'b0;
      settle();
      rd(A_DBC, 8'h51);
      rd(A_SST0, 8'h00);
      sync <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         tgt <= k[0];
         wr(A_TRANSFER_CONTROL, {tp_t[k], 5'h01});
         wr(A_SC3, {1'b1, scf_t[k], k[0], 3'h0});
         for (int i = 0; i < 5; i++) begin
            seed = lfsr(seed);
            wr(A_DATA, seed[7:0]);
            bq.push_back({i > 1 ? period(k) : 8'h00, seed[7:0]});
         end
         idle(20);
         if (k == 0) rd(A_SST0, 8'h60);
         idle(1);
         settle();
      end
      sync <= 1'b0;
      tgt <= 1'b0;
      wr(A_SC3, 8'h20);
      wr(A_TRANSFER_CONTROL, 8'h01);
      idle(2);
      for (int i = 0; i < 3; i++) begin
         seed = lfsr(seed);
         rx_b[i] = seed[7:0];
         i_peer.send_sync(seed[7:0]);
      end
      idle(20);
      for (int i = 0; i < 3; i++) rd(A_DATA, rx_b[i]);
      rd(A_DATA, 8'h00);
      sel_instr_busy <= 1'b1;
      wr(A_IEN0, 8'h30);
      wr(A_OWN_ID_REGISTER, 8'h02);
      idle(1);
      i_peer.select(1'b0, 3'h2);
      rd(A_IST0, 8'h00);
      wr(A_OWN_ID_REGISTER, 8'h22);
      idle(1);
      i_peer.select(1'b0, 3'h2);
      cmp_reg({7'h0, interrupt_request_n}, 8'h00);
      cmp_reg(8'(n_br), 8'h01);
      rd(A_IST0, 8'h20);
      idle(4);
      cmp_reg({7'h0, interrupt_request_n}, 8'h01);
      sel_instr_busy <= 1'b0;
      i_peer.select(1'b1, 3'h2);
      rd(A_IST0, 8'h00);
      wr(A_OWN_ID_REGISTER, 8'h62);
      idle(1);
      i_peer.select(1'b1, 3'h2);
      rd(A_IST0, 8'h10);
      rd(A_IST0, 8'h00);
      wr(A_IEN0, 8'h00);
      idle(1);
      i_peer.select(1'b0, 3'h2);
      cmp_reg({7'h0, interrupt_request_n}, 8'h01);
      rd(A_IST0, 8'h20);
      idle(4);
      cmp_reg(8'(n_br), 8'h01);
      wrap_up();
   end
endmodule : scsidp_top_test
